// ==== src/fpa_pkg.sv ====
// Shared types and constants of the fixed-point add, subtract, multiply and divide unit
`default_nettype none

package fpa_pkg;

   // ----------------------------------------------------------------
   // Register numbers and instruction lengths
   // ----------------------------------------------------------------
   localparam logic [3:0] BASE_REG_ONE = 4'h1;
   localparam logic [3:0] PAIR_BIT = 4'h1;
   localparam logic [15:0] LEN_TWO = 16'h0002;
   localparam logic [15:0] LEN_THREE = 16'h0003;

   // ----------------------------------------------------------------
   // Execution times
   // ----------------------------------------------------------------
   localparam int CLK_MHZ = 25;
   localparam int T_REG_ADD_NS = 800;
   localparam int T_IMM_ADD_NS = 1600;
   localparam int T_SHORT_ADD_NS = 1870;
   localparam int CYC_REG_ADD = (T_REG_ADD_NS * CLK_MHZ + 999) / 1000;
   localparam int CYC_IMM_ADD = (T_IMM_ADD_NS * CLK_MHZ + 999) / 1000;
   localparam int CYC_SHORT_ADD = (T_SHORT_ADD_NS * CLK_MHZ + 999) / 1000;
   localparam logic [5:0] CYC_MIN = 6'h01;

   // ----------------------------------------------------------------
   // Operations and operand sources
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      OP_ADD = 3'b000,
      OP_ADD_MEM = 3'b001,
      OP_ADD_MEM_BR = 3'b010,
      OP_ADD_REG_BR = 3'b011,
      OP_DADD = 3'b100,
      OP_SUB = 3'b101,
      OP_MUL = 3'b110,
      OP_DIV = 3'b111
   } fpa_op_t;

   typedef enum logic [2:0] {
      MODE_REG = 3'b000,
      MODE_IMM = 3'b001,
      MODE_EA = 3'b010,
      MODE_DISP = 3'b011,
      MODE_INDEX = 3'b100
   } fpa_mode_t;

   // ----------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      fpa_op_t op;
      fpa_mode_t mode;
      logic [3:0] dest_reg;
      logic [3:0] src_reg;
      logic [3:0] disp_field;
      logic [15:0] program_counter_reg;
      logic [15:0] second_word;
      logic [15:0] third_word;
      logic [15:0] effective_location;
   } fpa_req_t;

   typedef struct packed {
      logic we;
      logic [3:0] addr;
      logic [15:0] data;
   } fpa_rf_wr_t;

   typedef struct packed {
      logic we;
      logic [15:0] addr;
      logic [15:0] wdata;
   } fpa_mem_cmd_t;

endpackage : fpa_pkg

`default_nettype wire

// ==== src/fpa_unit.sv ====
// Fixed-point arithmetic execution unit with register file and memory sequencing
//
// Behaviour
// - Add flags overflow when like-signed addends give a sum of opposite sign.
// - Subtract flags overflow when result sign equals subtrahend sign, not minuend.
// - Multiply never flags overflow; other operations use their own condition.
// - Multiply with even destination writes 32-bit product, high half in even.
// - Multiply with odd destination writes only product low 16 bits there.
// - Divide takes pair dividend; quotient to odd register, remainder to even.
// - Divide overflow is raised when the quotient cannot fit 16 bits.
// - Divide overflow when dividend sign and top magnitude bit differ.
// - Divide overflow unless shifted upper half magnitude is below divisor magnitude.
// - Double add uses 32-bit operands, divide a 32-bit dividend; all others 16-bit words.
// - Register-to-memory add writes sum to memory, register left unchanged.
// - Full-address add-branch: nonzero sum jumps to third word, else next instruction.
// - Short add-branch: nonzero sum jumps to second word, else advance by two.
// - Register add-branch writes sum, branches to effective location when nonzero.
// - Double register add sums two even-odd pairs into destination pair.
// - Immediate forms take the word after the opcode as second operand.
// - Displaced address is base register one plus displacement; indexed uses pointer.
// - Memory subtract stores register minus memory operand in destination.
// - Register add 0.8 us, immediate add 1.6 us, short add 1.87 us.
// - Pair partner number is destination number OR one.
`default_nettype none

module fpa_unit (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Operation request
   input wire logic req_valid,
   output logic req_ready,
   input wire fpa_pkg::fpa_req_t req,
   output logic done,
   // Register file
   output logic [3:0] rf_raddr_a,
   output logic [3:0] rf_raddr_b,
   input wire logic [15:0] rf_rdata_a,
   input wire logic [15:0] rf_rdata_b,
   output var fpa_pkg::fpa_rf_wr_t rf_wr,
   // Memory
   output logic mem_req,
   output var fpa_pkg::fpa_mem_cmd_t mem_cmd,
   input wire logic mem_ack,
   input wire logic [15:0] mem_rdata,
   // Program register
   output logic pc_load,
   output logic [15:0] pc_value,
   // Overflow indicator
   input wire logic ovf_clear,
   output logic ovf_flag
);
   import fpa_pkg::*;

   typedef enum logic [3:0] {
      ST_IDLE = 4'b0000,
      ST_RD_DEST = 4'b0001,
      ST_RD_SRC = 4'b0010,
      ST_MEM_RD = 4'b0011,
      ST_EXEC = 4'b0100,
      ST_MEM_WR = 4'b0101,
      ST_WB_HI = 4'b0110,
      ST_WB_LO = 4'b0111,
      ST_HOLD = 4'b1000
   } fpa_state_t;

   fpa_state_t state;
   fpa_state_t next_state;
   fpa_req_t cur;
   logic [15:0] a_hi;
   logic [15:0] a_lo;
   logic [15:0] b_hi;
   logic [15:0] b_lo;
   logic [15:0] m;
   logic [15:0] res_hi;
   logic [15:0] res_lo;
   logic res_pair;
   logic [5:0] elapsed;
   logic [5:0] min_cyc;
   logic time_ok;
   logic [3:0] partner;
   logic mem_mode;

   // Combinational results of the execute step
   logic [15:0] add_sum;
   logic [15:0] sub_dif;
   logic [31:0] dsum;
   logic [31:0] prod;
   logic [31:0] dividend;
   logic [15:0] upper;
   logic [16:0] mag_up;
   logic [16:0] mag_dv;
   logic div_ovf;
   logic [31:0] quot;
   logic [31:0] rem;
   logic add_ovf;
   logic sub_ovf;
   logic dadd_ovf;
   logic next_ovf;
   logic [15:0] next_hi;
   logic [15:0] next_lo;
   logic next_pair;
   logic [15:0] branch_sum;
   logic [15:0] next_pc;

   function automatic logic [16:0] mag17(input logic [15:0] v);
      logic [16:0] x;
      x = {v[15], v};
      return v[15] ? (17'h00000 - x) : x;
   endfunction : mag17

   assign partner = cur.dest_reg | PAIR_BIT;
   assign mem_mode = (cur.mode == MODE_EA) || (cur.mode == MODE_DISP) ||
      (cur.mode == MODE_INDEX);
   assign req_ready = (state == ST_IDLE);
   assign time_ok = (elapsed >= min_cyc - CYC_MIN);
   assign done = (state == ST_HOLD) && time_ok;
   assign pc_load = done && ((cur.op == OP_ADD_MEM_BR) || (cur.op == OP_ADD_REG_BR));
   assign mem_req = (state == ST_MEM_RD) || (state == ST_MEM_WR);

   // ----------------------------------------------------------------
   // Register file read addressing
   // ----------------------------------------------------------------
   always_comb begin
      rf_raddr_a = cur.dest_reg;
      rf_raddr_b = partner;
      if (state == ST_RD_SRC) begin
         rf_raddr_a = (cur.mode == MODE_DISP) ? BASE_REG_ONE : cur.src_reg;
         rf_raddr_b = cur.src_reg | PAIR_BIT;
      end
   end

   // ----------------------------------------------------------------
   // Execute step
   // ----------------------------------------------------------------
   always_comb begin
      add_sum = a_hi + m;
      sub_dif = a_hi - m;
      dsum = {a_hi, a_lo} + {b_hi, b_lo};
      prod = 32'($signed(m) * $signed(a_lo));
      dividend = {a_hi, a_lo};
      upper = dividend[30:15];
      mag_up = mag17(upper);
      mag_dv = mag17(m);
      div_ovf = (dividend[31] != dividend[30]) || !(mag_up < mag_dv);
      quot = 32'h00000000;
      rem = 32'h00000000;
      if (m != 16'h0000) begin
         quot = 32'($signed(dividend) / $signed({{16{m[15]}}, m}));
         rem = 32'($signed(dividend) % $signed({{16{m[15]}}, m}));
      end
      add_ovf = (a_hi[15] == m[15]) && (add_sum[15] != a_hi[15]);
      sub_ovf = (sub_dif[15] == m[15]) && (sub_dif[15] != a_hi[15]);
      dadd_ovf = (a_hi[15] == b_hi[15]) && (dsum[31] != a_hi[15]);
      next_ovf = 1'b0;
      next_hi = add_sum;
      next_lo = 16'h0000;
      next_pair = 1'b0;
      case (cur.op)
         OP_ADD, OP_ADD_MEM, OP_ADD_MEM_BR, OP_ADD_REG_BR: begin
            next_ovf = add_ovf;
         end
         OP_SUB: begin
            next_hi = sub_dif;
            next_ovf = sub_ovf;
         end
         OP_DADD: begin
            next_hi = dsum[31:16];
            next_lo = dsum[15:0];
            next_pair = 1'b1;
            next_ovf = dadd_ovf;
         end
         OP_MUL: begin
            next_ovf = 1'b0;
            if (cur.dest_reg[0]) begin
               next_hi = prod[15:0];
            end else begin
               next_hi = prod[31:16];
               next_lo = prod[15:0];
               next_pair = 1'b1;
            end
         end
         OP_DIV: begin
            next_hi = rem[15:0];
            next_lo = quot[15:0];
            next_pair = 1'b1;
            next_ovf = div_ovf;
         end
         default: begin
            next_hi = add_sum;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // Branch target
   // ----------------------------------------------------------------
   always_comb begin
      branch_sum = add_sum;
      next_pc = cur.program_counter_reg + LEN_TWO;
      if (cur.op == OP_ADD_REG_BR) begin
         if (branch_sum != 16'h0000) begin
            next_pc = cur.effective_location;
         end
      end else if (cur.mode == MODE_EA) begin
         next_pc = (branch_sum != 16'h0000) ? cur.third_word :
            cur.program_counter_reg + LEN_THREE;
      end else if (branch_sum != 16'h0000) begin
         next_pc = cur.second_word;
      end
   end

   // ----------------------------------------------------------------
   // Sequencing
   // ----------------------------------------------------------------
   always_comb begin
      next_state = state;
      case (state)
         ST_IDLE: if (req_valid) next_state = ST_RD_DEST;
         ST_RD_DEST: next_state = ST_RD_SRC;
         ST_RD_SRC: next_state = mem_mode ? ST_MEM_RD : ST_EXEC;
         ST_MEM_RD: if (mem_ack) next_state = ST_EXEC;
         ST_EXEC: begin
            if (cur.op == OP_ADD_MEM || cur.op == OP_ADD_MEM_BR) begin
               next_state = ST_MEM_WR;
            end else if (cur.op == OP_DIV && div_ovf) begin
               next_state = ST_HOLD;
            end else begin
               next_state = ST_WB_HI;
            end
         end
         ST_MEM_WR: if (mem_ack) next_state = ST_HOLD;
         ST_WB_HI: next_state = res_pair ? ST_WB_LO : ST_HOLD;
         ST_WB_LO: next_state = ST_HOLD;
         ST_HOLD: if (time_ok) next_state = ST_IDLE;
         default: next_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state <= ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // Request capture and minimum execution time
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         cur <= '0;
         min_cyc <= CYC_MIN;
      end else if (state == ST_IDLE && req_valid) begin
         cur <= req;
         min_cyc <= CYC_MIN;
         if (req.op == OP_ADD) begin
            case (req.mode)
               MODE_REG: min_cyc <= 6'(CYC_REG_ADD);
               MODE_IMM: min_cyc <= 6'(CYC_IMM_ADD);
               MODE_DISP, MODE_INDEX: min_cyc <= 6'(CYC_SHORT_ADD);
               default: min_cyc <= CYC_MIN;
            endcase
         end
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         elapsed <= 6'h00;
      end else if (state == ST_IDLE) begin
         elapsed <= 6'h00;
      end else if (elapsed != 6'h3F) begin
         elapsed <= elapsed + 6'h01;
      end
   end

   // ----------------------------------------------------------------
   // Operand capture
   // ----------------------------------------------------------------
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         a_hi <= 16'h0000;
         a_lo <= 16'h0000;
         b_hi <= 16'h0000;
         b_lo <= 16'h0000;
         m <= 16'h0000;
      end else begin
         if (state == ST_RD_DEST) begin
            a_hi <= rf_rdata_a;
            a_lo <= rf_rdata_b;
         end
         if (state == ST_RD_SRC) begin
            b_hi <= rf_rdata_a;
            b_lo <= rf_rdata_b;
            m <= (cur.mode == MODE_IMM) ? cur.second_word : rf_rdata_a;
         end
         if (state == ST_MEM_RD && mem_ack) begin
            m <= mem_rdata;
         end
      end
   end

   // ----------------------------------------------------------------
   // Memory command
   // ----------------------------------------------------------------
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         mem_cmd <= '0;
      end else if (state == ST_RD_SRC) begin
         mem_cmd.we <= 1'b0;
         case (cur.mode)
            MODE_DISP: mem_cmd.addr <= rf_rdata_a + {12'h000, cur.disp_field};
            MODE_INDEX: mem_cmd.addr <= rf_rdata_a;
            default: mem_cmd.addr <= cur.effective_location;
         endcase
      end else if (state == ST_EXEC) begin
         mem_cmd.we <= 1'b1;
         mem_cmd.wdata <= add_sum;
      end
   end

   // ----------------------------------------------------------------
   // Results, write-back and program register
   // ----------------------------------------------------------------
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         res_hi <= 16'h0000;
         res_lo <= 16'h0000;
         res_pair <= 1'b0;
         pc_value <= 16'h0000;
      end else if (state == ST_EXEC) begin
         res_hi <= next_hi;
         res_lo <= next_lo;
         res_pair <= next_pair;
         pc_value <= next_pc;
      end
   end

   always_comb begin
      rf_wr.we = (state == ST_WB_HI) || (state == ST_WB_LO);
      rf_wr.addr = (state == ST_WB_LO) ? partner : cur.dest_reg;
      rf_wr.data = (state == ST_WB_LO) ? res_lo : res_hi;
   end

   // Sticky overflow: a new overflow beats a clear in the same cycle
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         ovf_flag <= 1'b0;
      end else if (state == ST_EXEC && next_ovf) begin
         ovf_flag <= 1'b1;
      end else if (ovf_clear) begin
         ovf_flag <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   logic exec;
   assign exec = (state == ST_EXEC);

   sequence wb_dest_s(logic [15:0] v);
      rf_wr.we && rf_wr.addr == cur.dest_reg && rf_wr.data == v;
   endsequence
   sequence wb_partner_s(logic [15:0] v);
      rf_wr.we && rf_wr.addr == (cur.dest_reg | PAIR_BIT) && rf_wr.data == v;
   endsequence

   add_overflow_a: assert property (
      (exec && cur.op == OP_ADD && a_hi[15] == m[15] && add_sum[15] != m[15]) |=> ovf_flag)
      else $error("add overflow not flagged");
   sub_overflow_a: assert property (
      (exec && cur.op == OP_SUB && sub_dif[15] == m[15] && sub_dif[15] != a_hi[15])
      |=> ovf_flag)
      else $error("subtract overflow not flagged");
   mul_keeps_ovf_a: assert property (
      (exec && cur.op == OP_MUL && !ovf_clear) |=> ovf_flag == $past(ovf_flag))
      else $error("multiply changed overflow");
   mul_even_pair_a: assert property (
      (exec && cur.op == OP_MUL && !cur.dest_reg[0])
      |=> wb_dest_s($past(prod[31:16])) ##1 wb_partner_s($past(prod[15:0], 2)))
      else $error("even multiply write-back wrong");
   mul_odd_low_a: assert property (
      (exec && cur.op == OP_MUL && cur.dest_reg[0])
      |=> wb_dest_s($past(prod[15:0])) ##1 !rf_wr.we)
      else $error("odd multiply write-back wrong");
   div_pair_wb_a: assert property (
      (exec && cur.op == OP_DIV && !div_ovf)
      |=> wb_dest_s($past(rem[15:0])) ##1 wb_partner_s($past(quot[15:0], 2)))
      else $error("divide write-back wrong");
   div_ovf_nowb_a: assert property (
      (exec && cur.op == OP_DIV && div_ovf) |=> !rf_wr.we [*2])
      else $error("divide overflow still wrote");
   div_sign_ovf_a: assert property (
      (exec && cur.op == OP_DIV && a_hi[15] != a_hi[14]) |=> ovf_flag)
      else $error("divide sign overflow missed");
   div_mag_ovf_a: assert property (
      (exec && cur.op == OP_DIV && !(mag_up < mag_dv)) |=> ovf_flag)
      else $error("divide magnitude overflow missed");
   mem_add_a: assert property (
      (exec && cur.op == OP_ADD_MEM)
      |=> (mem_req && mem_cmd.we && mem_cmd.wdata == $past(add_sum) && !rf_wr.we))
      else $error("memory add result misrouted");
   full_branch_a: assert property (
      (pc_load && cur.op == OP_ADD_MEM_BR && cur.mode == MODE_EA)
      |-> pc_value == ((mem_cmd.wdata != 16'h0000) ? cur.third_word :
         cur.program_counter_reg + LEN_THREE))
      else $error("full branch target wrong");
   short_branch_a: assert property (
      (pc_load && cur.op == OP_ADD_MEM_BR && cur.mode != MODE_EA)
      |-> pc_value == ((mem_cmd.wdata != 16'h0000) ? cur.second_word :
         cur.program_counter_reg + LEN_TWO))
      else $error("short branch target wrong");
   imm_operand_a: assert property (
      (state == ST_RD_SRC && cur.mode == MODE_IMM) |=> m == $past(cur.second_word))
      else $error("immediate operand wrong");
   disp_address_a: assert property (
      (state == ST_RD_SRC && cur.mode == MODE_DISP)
      |-> rf_raddr_a == BASE_REG_ONE ##1
         mem_cmd.addr == $past(rf_rdata_a) + {12'h000, cur.disp_field})
      else $error("displaced address wrong");
   add_time_a: assert property (
      done |-> elapsed + CYC_MIN >= min_cyc)
      else $error("operation finished early");
   ovf_sticky_a: assert property (
      (ovf_flag && !ovf_clear) |=> ovf_flag)
      else $error("overflow lost");

endmodule : fpa_unit

`default_nettype wire

// ==== tb/fpa_env_model.sv ====
// Register file and memory model that stands beside the arithmetic unit
`default_nettype none

module fpa_env_model (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Register file
   input wire logic [3:0] rf_raddr_a,
   input wire logic [3:0] rf_raddr_b,
   output logic [15:0] rf_rdata_a,
   output logic [15:0] rf_rdata_b,
   input wire fpa_pkg::fpa_rf_wr_t rf_wr,
   // Memory
   input wire logic mem_req,
   input wire fpa_pkg::fpa_mem_cmd_t mem_cmd,
   output logic mem_ack,
   output logic [15:0] mem_rdata,
   input wire logic [1:0] slow
);
   timeunit 1ns;
   timeprecision 1ns;
   import fpa_pkg::*;

   logic [15:0] regs [16];
   logic [15:0] mem [256];
   logic [1:0] cnt;

   // Reads answer in the same cycle
   assign rf_rdata_a = regs[rf_raddr_a];
   assign rf_rdata_b = regs[rf_raddr_b];

   always @(posedge clk) begin
      if (rf_wr.we) begin
         regs[rf_wr.addr] <= rf_wr.data;
      end
   end

   // Memory answers after 0 to 3 wait cycles
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         mem_ack <= 1'b0;
         cnt <= 2'h0;
         mem_rdata <= 16'h0000;
      end else if (mem_req && !mem_ack && cnt >= slow) begin
         mem_ack <= 1'b1;
         cnt <= 2'h0;
         mem_rdata <= mem[mem_cmd.addr[7:0]];
         if (mem_cmd.we) begin
            mem[mem_cmd.addr[7:0]] <= mem_cmd.wdata;
         end
      end else begin
         mem_ack <= 1'b0;
         // Released data must not look valid
         mem_rdata <= ~mem_rdata;
         if (mem_req && !mem_ack) begin
            cnt <= cnt + 2'h1;
         end
      end
   end
endmodule : fpa_env_model

`default_nettype wire

// ==== tb/fpa_unit_tb.sv ====
// Self-checking bench for the fixed-point arithmetic unit
`default_nettype none

module fpa_unit_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import fpa_pkg::*;

   typedef struct {logic ld; logic [15:0] pc; logic ovf;} fpa_note_t;
   logic clk, reset, req_valid, req_ready, done, mem_req, mem_ack;
   logic pc_load, ovf_clear, ovf_flag;
   logic [3:0] ra_a, ra_b;
   logic [15:0] rd_a, rd_b, mem_rdata, pc_value;
   logic [1:0] slow;
   fpa_req_t req;
   fpa_rf_wr_t rf_wr;
   fpa_mem_cmd_t mem_cmd;
   fpa_note_t notes[$];
   int miscompares = 0;
   int n_checks = 0;

   fpa_unit dut_u (.clk(clk), .reset(reset), .req_valid(req_valid), .req_ready(req_ready),
      .req(req), .done(done), .rf_raddr_a(ra_a), .rf_raddr_b(ra_b), .rf_rdata_a(rd_a),
      .rf_rdata_b(rd_b), .rf_wr(rf_wr), .mem_req(mem_req), .mem_cmd(mem_cmd),
      .mem_ack(mem_ack), .mem_rdata(mem_rdata), .pc_load(pc_load), .pc_value(pc_value),
      .ovf_clear(ovf_clear), .ovf_flag(ovf_flag));
   fpa_env_model m_u (.clk(clk), .reset(reset), .rf_raddr_a(ra_a), .rf_raddr_b(ra_b),
      .rf_rdata_a(rd_a), .rf_rdata_b(rd_b), .rf_wr(rf_wr), .mem_req(mem_req),
      .mem_cmd(mem_cmd), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .slow(slow));

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // ----------------------------------------
   // Compare and drive tasks
   // ----------------------------------------
   task automatic chk_word(input logic [15:0] got, input logic [15:0] exp, input string w);
      n_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch at %0t: %s got %h expected %h", $time, w, got, exp);
      end
   endtask : chk_word

   task automatic chk_bit(input logic got, input logic exp, input string w);
      n_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch at %0t: %s got %b expected %b", $time, w, got, exp);
      end
   endtask : chk_bit

   task automatic summarize;
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : summarize

   function automatic logic ova(input logic [15:0] a, input logic [15:0] b,
                                input logic [15:0] s);
      return (a[15] == b[15]) && (s[15] != a[15]);
   endfunction : ova

   task automatic setr(input logic [3:0] r, input logic [15:0] v);
      m_u.regs[r] = v;
   endtask : setr

   task automatic regchk(input logic [3:0] r, input logic [15:0] v);
      chk_word(m_u.regs[r], v, "register");
   endtask : regchk

   task automatic run(input fpa_op_t op, input fpa_mode_t md, input logic [3:0] d,
      input logic [3:0] s, input logic [15:0] w2, input logic [15:0] w3,
      input logic [15:0] ea, input logic ld, input logic [15:0] epc, input logic eovf,
      input logic clr, input int min_cyc);
      int cyc;
      notes.push_back('{ld, epc, eovf});
      ovf_clear = clr;
      @(negedge clk);
      ovf_clear = 1'b0;
      req = '{op, md, d, s, 4'h4, 16'h0100, w2, w3, ea};
      req_valid = 1'b1;
      @(negedge clk);
      req_valid = 1'b0;
      cyc = 1;
      while (done !== 1'b1 && cyc < 3000) begin
         @(negedge clk);
         cyc++;
      end
      chk_bit(done, 1'b1, "completion");
      if (min_cyc > 0) chk_bit(cyc >= min_cyc, 1'b1, "duration");
      @(negedge clk);
   endtask : run

   // Results noted by the driver are matched as done appears
   always @(negedge clk) begin
      fpa_note_t n;
      if (done === 1'b1) begin
         if (notes.size() == 0) begin
            chk_bit(1'b0, 1'b1, "unexpected done");
         end else begin
            n = notes.pop_front();
            chk_bit(pc_load, n.ld, "pc load");
            if (n.ld) chk_word(pc_value, n.pc, "pc value");
            chk_bit(ovf_flag, n.ovf, "overflow");
         end
      end
   end

   initial begin
      #(40 * 20000);
      miscompares++;
      summarize();
   end

   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial begin
      logic [15:0] a, b, s;
      reset = 1'b1;
      req_valid = 1'b0;
      req = '0;
      ovf_clear = 1'b0;
      slow = 2'h0;
      a = 16'($urandom(32'hb636));
      repeat (3) @(posedge clk);
      @(negedge clk);
      reset = 1'b0;
      for (int i = 0; i < 6; i++) begin
         a = (i == 1) ? 16'h7FFF : (i == 4) ? 16'h8000 : 16'($urandom);
         b = (i == 1) ? 16'h0001 : (i == 4) ? 16'h8000 : 16'($urandom);
         s = a + b;
         slow = 2'($urandom_range(3, 0));
         setr(4'h2, a);
         setr(4'h3, (i < 3) ? b : ~b);
         run(OP_ADD, fpa_mode_t'((i < 3) ? MODE_REG : MODE_IMM), 4'h2, 4'h3, b, 16'h0, 16'h0,
             1'b0, 16'h0, ova(a, b, s), 1'b1, (i < 3) ? CYC_REG_ADD : CYC_IMM_ADD);
         regchk(4'h2, s);
      end
      $display("test word add done");
      setr(4'h1, 16'h0010);
      m_u.mem[8'h14] = 16'h0102;
      setr(4'h2, 16'h0003);
      run(OP_ADD, MODE_DISP, 4'h2, 4'h0, 0, 0, 0, 0, 0, 1'b0, 1'b1, CYC_SHORT_ADD);
      regchk(4'h2, 16'h0105);
      setr(4'h5, 16'h0030);
      m_u.mem[8'h30] = 16'h0001;
      setr(4'h2, 16'h8000);
      run(OP_SUB, MODE_INDEX, 4'h2, 4'h5, 0, 0, 0, 0, 0, 1'b1, 1'b1, 0);
      regchk(4'h2, 16'h7FFF);
      $display("test short forms done");
      setr(4'h6, 16'h0011);
      m_u.mem[8'h40] = 16'h1234;
      m_u.mem[8'h41] = 16'h0005;
      m_u.mem[8'h42] = 16'hFFEF;
      slow = 2'h3;
      run(OP_ADD_MEM, MODE_EA, 4'h6, 4'h0, 0, 0, 16'h0040, 0, 0, 1'b0, 1'b1, 0);
      chk_word(m_u.mem[8'h40], 16'h1245, "memory sum");
      regchk(4'h6, 16'h0011);
      run(OP_ADD_MEM_BR, MODE_EA, 4'h6, 4'h0, 0, 16'h0200, 16'h0041, 1, 16'h0200, 0, 1,
         0);
      run(OP_ADD_MEM_BR, MODE_EA, 4'h6, 4'h0, 0, 16'h0200, 16'h0042, 1, 16'h0103, 0, 1,
         0);
      chk_word(m_u.mem[8'h42], 16'h0000, "memory zero sum");
      run(OP_ADD_MEM_BR, MODE_DISP, 4'h6, 4'h0, 16'h0250, 0, 0, 1, 16'h0250, 0, 1,
         0);
      m_u.mem[8'h30] = 16'hFFEF;
      run(OP_ADD_MEM_BR, MODE_INDEX, 4'h6, 4'h5, 16'h0250, 0, 0, 1, 16'h0102, 0, 1,
         0);
      $display("test memory add and branch done");
      setr(4'h2, 16'h0001);
      setr(4'h3, 16'hFFFF);
      run(OP_ADD_REG_BR, MODE_REG, 4'h2, 4'h3, 0, 0, 16'h0300, 1, 16'h0102, 0, 1,
         0);
      regchk(4'h2, 16'h0000);
      run(OP_ADD_REG_BR, MODE_REG, 4'h3, 4'h3, 0, 0, 16'h0300, 1, 16'h0300, 0, 1,
         0);
      regchk(4'h3, 16'hFFFE);
      $display("test register branch done");
      // Even pair numbers only, as the program must supply
      setr(4'h4, 16'h0001);
      setr(4'h5, 16'hFFFF);
      setr(4'h6, 16'h0000);
      setr(4'h7, 16'h0001);
      run(OP_DADD, MODE_REG, 4'h4, 4'h6, 0, 0, 0, 0, 0, 1'b0, 1'b1, 0);
      regchk(4'h4, 16'h0002);
      regchk(4'h5, 16'h0000);
      setr(4'h4, 16'h7FFF);
      setr(4'h5, 16'hFFFF);
      run(OP_DADD, MODE_REG, 4'h4, 4'h6, 0, 0, 0, 0, 0, 1'b1, 1'b1, 0);
      regchk(4'h4, 16'h8000);
      $display("test double add done");
      setr(4'h9, 16'hFFFD);
      setr(4'hA, 16'h0005);
      run(OP_MUL, MODE_REG, 4'h8, 4'hA, 0, 0, 0, 0, 0, 1'b1, 1'b0, 0);
      regchk(4'h8, 16'hFFFF);
      regchk(4'h9, 16'hFFF1);
      setr(4'h8, 16'h1357);
      setr(4'h9, 16'hFFFD);
      run(OP_MUL, MODE_REG, 4'h9, 4'hA, 0, 0, 0, 0, 0, 1'b0, 1'b1, 0);
      regchk(4'h9, 16'hFFF1);
      regchk(4'h8, 16'h1357);
      $display("test multiply done");
      setr(4'h2, 16'h0000);
      setr(4'h3, 16'h0064);
      setr(4'h4, 16'h0007);
      run(OP_DIV, MODE_REG, 4'h2, 4'h4, 0, 0, 0, 0, 0, 1'b0, 1'b1, 0);
      regchk(4'h2, 16'h0002);
      regchk(4'h3, 16'h000E);
      setr(4'h2, 16'h4000);
      setr(4'h3, 16'h0000);
      run(OP_DIV, MODE_REG, 4'h2, 4'h4, 0, 0, 0, 0, 0, 1'b1, 1'b1, 0);
      regchk(4'h2, 16'h4000);
      setr(4'h2, 16'h0000);
      setr(4'h3, 16'hFFFF);
      setr(4'h4, 16'h0002);
      run(OP_DIV, MODE_REG, 4'h2, 4'h4, 0, 0, 0, 0, 0, 1'b0, 1'b1, 0);
      regchk(4'h3, 16'h7FFF);
      regchk(4'h2, 16'h0001);
      setr(4'h2, 16'h0001);
      setr(4'h3, 16'h0000);
      run(OP_DIV, MODE_REG, 4'h2, 4'h4, 0, 0, 0, 0, 0, 1'b1, 1'b1, 0);
      $display("test divide done");
      summarize();
   end
endmodule : fpa_unit_tb

`default_nettype wire
